// ### soft_start_timing_control_bench.sv
// Self-checking bench for the soft-start timing control
`timescale 1ns/1ps
`default_nettype none
module soft_start_timing_control_bench import sst_pkg::*;;
  // Short tick keeps ms timers cheap
  localparam int QTR = 20;
  // One tick with its alignment cycle
  localparam int TK = QTR + 1;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  sst_cmd_s cmd;
  sst_rsp_s rsp, got;
  logic nvm_restore = 1'b0;
  sst_nvm_s nvm = '{delay_word: 16'hf00b, rise_word: 16'hf008,
                    tmo_word: 16'hf80a};
  logic start_cond = 1'b0;
  logic [15:0] vout_target = 16'h1000;
  logic stall = 1'b0;
  logic vout_at_85pct;
  logic [1:0] tmax_resp = 2'h2;
  logic power_enable, uv_fault_enable, ton_max_fault;
  logic [15:0] dac_ref;
  int n_mismatch = 0;
  int checked = 0;
  // Write table: code, word, readback after, rejection expected
  logic [7:0] wc [11] = '{8'h60, 8'h60, 8'h60, 8'h60, 8'h60, 8'h60,
    8'h61, 8'h61, 8'h61, 8'h61, 8'h62};
  logic [15:0] wd [11] = '{16'hf814, 16'hf9ff, 16'hf003, 16'hfc01,
    16'h0002, 16'hf8ff, 16'hf07f, 16'hf080, 16'he801, 16'hf801, 16'hf800};
  logic [15:0] wb [11] = '{16'hf814, 16'hf814, 16'hf814, 16'hf814,
    16'h0002, 16'hf8ff, 16'hf07f, 16'hf07f, 16'hf07f, 16'hf801, 16'hf80a};
  logic wbad [11] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1,
    1'b1, 1'b0, 1'b1};

  always #20 sys_clk = ~sys_clk;

  sst_soft_start_ctrl #(.QTR_CYC(QTR)) DUT (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .cmd(cmd), .rsp(rsp), .nvm_restore(nvm_restore),
    .nvm(nvm), .start_cond(start_cond), .vout_target(vout_target),
    .vout_at_85pct(vout_at_85pct), .tmax_resp(tmax_resp),
    .power_enable(power_enable), .dac_ref(dac_ref),
    .uv_fault_enable(uv_fault_enable), .ton_max_fault(ton_max_fault));

  sst_host_model host (.sys_clk(sys_clk), .cmd(cmd), .rsp(rsp),
    .dac_ref(dac_ref), .vout_target(vout_target), .stall(stall),
    .vout_at_85pct(vout_at_85pct));

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] data,
                    input logic bad);
    host.xfer(1'b1, code, data, got);
    check("invalid", got.invalid, bad);
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    host.xfer(1'b0, code, 16'h0000, got);
    check("rd_valid", got.rd_valid, 1'b1);
    check("rd_data", got.rd_data, exp);
  endtask

  function automatic logic flag(input int k);
    return k == 0 ? power_enable : k == 1 ? uv_fault_enable : ton_max_fault;
  endfunction

  // Bounded wait, counted in falling edges
  task automatic wait_for(input int k, input int lim, output int n);
    n = 0;
    while (flag(k) !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  // Start, then time the delay and the ramp
  task automatic start_run(input int lo, input int hi, input int rt);
    int n;
    @(negedge sys_clk);
    start_cond = 1'b1;
    wait_for(0, hi + 10, n);
    check("on delay", n >= lo && n <= hi, 1'b1);
    check("uv early", uv_fault_enable, 1'b0);
    wait_for(1, rt * TK + 10, n);
    check("ramp", n >= rt * QTR - 2 && n <= rt * TK + 3, 1'b1);
    check("ref end", dac_ref, vout_target);
  endtask

  task automatic stop_run();
    start_cond = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("off", power_enable, 1'b0);
  endtask

  // Stalled rail: fault time from end of ramp, response by code
  task automatic tmo_run(input logic [1:0] resp, input logic on);
    int n;
    tmax_resp = resp;
    stall = 1'b1;
    start_run(2495, 2510, 8);
    wait_for(2, 12 * TK + 10, n);
    check("tmo", n >= 12 * QTR - 10 && n <= 12 * TK + 10, 1'b1);
    check("resp", power_enable, on);
    @(negedge sys_clk);
    check("pulse", ton_max_fault, 1'b0);
    stop_run();
    stall = 1'b0;
  endtask

  // Watchdog sized well above the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial begin
    int n;
    repeat (5) @(negedge sys_clk);
    check("rst", {power_enable, uv_fault_enable, dac_ref}, 0);
    sys_rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    rd(CMD_DELAY, 16'hf806);
    rd(CMD_RISE, 16'hf008);
    rd(CMD_TMO, 16'hf80a);
    for (int i = 0; i < 11; i++) begin
      wr(wc[i], wd[i], wbad[i]);
      rd(wc[i], wb[i]);
    end
    host.xfer(1'b0, 8'h63, 16'h0000, got);
    check("unknown", {got.rd_valid, got.invalid}, 2'b00);
    // Zero delay, zero ramp runs the shortest ramp
    wr(CMD_DELAY, 16'hf800, 1'b0);
    wr(CMD_RISE, 16'hf000, 1'b0);
    start_run(2495, 2510, 2);
    stop_run();
    // Longest delay with an 8-tick ramp
    wr(CMD_RISE, 16'h0002, 1'b0);
    wr(CMD_DELAY, 16'hf8ff, 1'b0);
    start_run(510 * QTR - 10, 510 * TK + 10, 8);
    stop_run();
    // Same ramp at another target
    wr(CMD_DELAY, 16'hf800, 1'b0);
    vout_target = 16'h7ff0;
    start_run(2495, 2510, 8);
    stop_run();
    tmo_run(2'h2, 1'b0);
    tmo_run(RESP_IGNORE, 1'b1);
    // Restore with zero timeout
    nvm.tmo_word = 16'h0000;
    @(negedge sys_clk);
    nvm_restore = 1'b1;
    @(negedge sys_clk);
    nvm_restore = 1'b0;
    rd(CMD_TMO, 16'hf800);
    rd(CMD_DELAY, 16'hf806);
    wr(CMD_DELAY, 16'hf800, 1'b0);
    stall = 1'b1;
    start_run(2495, 2510, 8);
    wait_for(2, 600, n);
    check("no tmo", n, 600);
    stop_run();
    stop_test();
  end
endmodule
`default_nettype wire

// ### sst_div.sv
// Serial divider for the reference slew step
`timescale 1ns/1ps
`default_nettype none
module sst_div import sst_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [15:0] dividend,
  input wire logic [6:0] divisor,
  output logic [15:0] quotient,
  output logic busy
);
  logic [15:0] dvd_reg;
  logic [6:0] rem_reg;
  logic [4:0] cnt_reg;
  logic [7:0] trial;
  logic fits;

  // One restoring step per clock, sixteen in all
  always_comb begin
    trial = {rem_reg, dvd_reg[15]};
    fits = trial >= {1'b0, divisor};
  end

  // Remainder is dropped, so the step is floored
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dvd_reg <= '0;
      rem_reg <= '0;
      cnt_reg <= '0;
      quotient <= '0;
    end else if (start) begin
      dvd_reg <= dividend;
      rem_reg <= '0;
      cnt_reg <= 5'h10;
      quotient <= '0;
    end else if (cnt_reg != 5'h0) begin
      rem_reg <= fits ? 7'(trial - {1'b0, divisor}) : trial[6:0];
      quotient <= {quotient[14:0], fits};
      dvd_reg <= {dvd_reg[14:0], 1'b0};
      cnt_reg <= cnt_reg - 5'h1;
    end
  end

  assign busy = cnt_reg != 5'h0;
endmodule
`default_nettype wire

// ### sst_host_model.sv
// Host and output-sense model facing the soft-start block
`timescale 1ns/1ps
`default_nettype none
module sst_host_model import sst_pkg::*; (
  input wire logic sys_clk,
  output sst_cmd_s cmd,
  input wire sst_rsp_s rsp,
  input wire logic [15:0] dac_ref,
  input wire logic [15:0] vout_target,
  input wire logic stall,
  output logic vout_at_85pct
);
  // Sensed output follows the reference; stall models a slow rail
  always_comb begin
    vout_at_85pct = !stall &&
      ({8'h00, dac_ref} * 24'h14 >= {8'h00, vout_target} * 24'h11);
  end

  // Bus idle from time zero
  initial cmd = '0;

  // One word command: set after a falling edge, taken at the rising
  // edge, answer sampled one falling edge later
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic [15:0] data, output sst_rsp_s got);
    @(negedge sys_clk);
    cmd <= '{valid: 1'b1, write: wr, code: code, wdata: data};
    @(negedge sys_clk);
    got = rsp;
    // Released fields show no stale value
    cmd <= '{valid: 1'b0, write: ~wr, code: ~code, wdata: ~data};
  endtask
endmodule
`default_nettype wire

// ### sst_pkg.sv
// Shared constants, carriers and linear-format helpers for soft start
package sst_pkg;
  // Command codes of the three timing words
  localparam logic [7:0] CMD_DELAY = 8'h60;
  localparam logic [7:0] CMD_RISE = 8'h61;
  localparam logic [7:0] CMD_TMO = 8'h62;
  // Linear word layout: exponent on top, mantissa below
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;
  // Exponents after reset; mantissas come from NVM
  localparam logic [4:0] DELAY_EXP_RST = 5'h1f;
  localparam logic [4:0] RISE_EXP_RST = 5'h1e;
  localparam logic [4:0] TMO_EXP_RST = 5'h1f;
  localparam logic [10:0] MAN_RST = 11'h000;
  // Clock and timing figures
  localparam int CLK_PERIOD_NS = 40;
  localparam int INIT_TIME_US = 100;
  localparam int QTR_TIME_US = 250;
  // Least time, so rounded up
  localparam logic [11:0] INIT_LAST =
    12'((INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Shift bases: to half-ms units and to quarter-ms units
  localparam logic [5:0] BASE_HALF = 6'h01;
  localparam logic [5:0] BASE_QTR = 6'h02;
  // Limits in units after conversion
  localparam logic [23:0] LIM_ZERO = 24'h000000;
  localparam logic [23:0] DELAY_MAX_HALF = 24'h0000ff;
  localparam logic [23:0] RISE_MIN_QTR = 24'h000002;
  localparam logic [23:0] RISE_MAX_QTR = 24'h00007f;
  localparam logic [23:0] TMO_MAX_HALF = 24'h0000fe;
  // Timeout response code that keeps the rail running
  localparam logic [1:0] RESP_IGNORE = 2'h0;

  // Word command from the management bus front end
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } sst_cmd_s;

  // Answer back to the front end
  typedef struct packed {
    logic rd_valid;
    logic [15:0] rd_data;
    logic invalid;
  } sst_rsp_s;

  // Words held in nonvolatile memory
  typedef struct packed {
    logic [15:0] delay_word;
    logic [15:0] rise_word;
    logic [15:0] tmo_word;
  } sst_nvm_s;

  // Result of a linear-to-units conversion
  typedef struct packed {
    logic neg;
    logic big;
    logic exact;
    logic [23:0] units;
    logic [23:0] near;
  } sst_conv_s;

  // Start-up sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DELAY = 5'h02,
    ST_RAMP = 5'h04,
    ST_REG = 5'h08,
    ST_FAULT = 5'h10
  } sst_state_e;

  // Mantissa times two to the exponent, scaled into units
  function automatic sst_conv_s lin_units(input logic [15:0] w,
                                          input logic [5:0] base);
    sst_conv_s r;
    logic signed [5:0] sh;
    logic [4:0] n;
    logic [23:0] m;
    logic [23:0] mask;
    r = '0;
    sh = signed'({w[EXP_MSB], w[EXP_MSB:EXP_LSB]} + base);
    m = {13'h0, w[MAN_MSB:0]};
    n = 5'(-sh);
    mask = (24'h1 << n) - 24'h1;
    r.neg = w[MAN_MSB];
    if (sh > 6'sh0c) begin
      // Too large for any setting unless zero
      r.big = |m;
      r.exact = 1'b1;
    end else if (sh >= 6'sh00) begin
      r.units = m << sh[3:0];
      r.near = r.units;
      r.exact = 1'b1;
    end else begin
      r.units = m >> n;
      r.near = (m + (mask >> 1) + 24'h1) >> n;
      r.exact = (m & mask) == 24'h0;
    end
    return r;
  endfunction

  // Value on an exact step and inside the range
  function automatic logic lin_ok(input sst_conv_s c,
                                  input logic [23:0] maxv);
    return !c.neg && !c.big && c.exact && c.units <= maxv;
  endfunction

  // Force a value into a range of units
  function automatic logic [9:0] clamp_units(input sst_conv_s c,
                                             input logic [23:0] lo,
                                             input logic [23:0] hi);
    if (c.neg || c.units < lo)
      return lo[9:0];
    else if (c.big || c.units > hi)
      return hi[9:0];
    else
      return c.units[9:0];
  endfunction
endpackage

// ### sst_soft_start_ctrl.sv
// Start-up delay, soft-start ramp and start-up timeout control
//
// Functional notes
// - wait programmed delay before output rises
// - 16-bit linear words, word read and write
// - exponent resets fixed, mantissas from NVM
// - about 100 us minimum delay always
// - delay 0 to 127.5 ms, 0.5 ms steps
// - restore rounds delay to nearest step
// - reject out-of-range delay or ramp writes
// - ramp time sets reference slew rate
// - ramp length independent of target voltage
// - ramp 0 to 31.75 ms, 0.25 ms steps
// - ramps under 0.5 ms run 0.5 ms
// - slew quantization may merge ramp settings
// - timeout from delay end to 85 percent
// - undervoltage detection enabled after ramp
// - timeout 0 to 127 ms, writes flagged
// - zero timeout disables timeout detection
// - timeout fault follows configured response
`timescale 1ns/1ps
`default_nettype none
module sst_soft_start_ctrl import sst_pkg::*; #(
  parameter int unsigned QTR_CYC = QTR_TIME_US * 1000 / CLK_PERIOD_NS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire sst_cmd_s cmd,
  output var sst_rsp_s rsp,
  input wire logic nvm_restore,
  input wire sst_nvm_s nvm,
  input wire logic start_cond,
  input wire logic [15:0] vout_target,
  input wire logic vout_at_85pct,
  input wire logic [1:0] tmax_resp,
  output logic power_enable,
  output logic [15:0] dac_ref,
  output logic uv_fault_enable,
  output logic ton_max_fault
);
  // Timing words as the host sees them
  logic [15:0] delay_reg, rise_reg, tmo_reg;
  // Power-up restore still owed, and its request term
  logic restore_pend_reg, do_restore;
  sst_rsp_s rsp_reg;
  sst_state_e state_reg, state_next;
  // Quarter-ms ticks spent in the current phase
  logic [9:0] phase_reg;
  // Quarter-ms ticks since the delay ended
  logic [9:0] tmo_cnt_reg;
  logic tmo_arm_reg;
  // Cycles of the fixed initialisation window
  logic [11:0] init_reg;
  logic [15:0] dac_reg;
  logic fault_reg;
  // Decoded settings
  sst_conv_s delay_c, rise_c, tmo_c, wr_c, nvd_c;
  // Settings in half-ms and quarter-ms ticks
  logic [9:0] delay_h, tmo_h, delay_q, rise_q, tmo_q, nvd_h;
  // Command decode
  logic is_wr, is_rd, known, wr_ok;
  // Sequencer terms
  logic restart, tick, div_start;
  logic [15:0] step;
  logic [16:0] dac_sum;
  logic init_done, delay_done, ramp_done, tmo_hit;

  // Settings turned into tick counts
  always_comb begin
    delay_c = lin_units(delay_reg, BASE_HALF);
    rise_c = lin_units(rise_reg, BASE_QTR);
    tmo_c = lin_units(tmo_reg, BASE_HALF);
    nvd_c = lin_units(nvm.delay_word, BASE_HALF);
    nvd_c.units = nvd_c.near;
    nvd_h = clamp_units(nvd_c, LIM_ZERO, DELAY_MAX_HALF);
    delay_h = clamp_units(delay_c, LIM_ZERO, DELAY_MAX_HALF);
    delay_q = {delay_h[8:0], 1'b0};
    // Short ramps are stretched to two quarter ticks
    rise_q = clamp_units(rise_c, RISE_MIN_QTR, RISE_MAX_QTR);
    tmo_h = clamp_units(tmo_c, LIM_ZERO, TMO_MAX_HALF);
    tmo_q = {tmo_h[8:0], 1'b0};
  end

  // Write check on the converted value
  always_comb begin
    is_wr = cmd.valid && cmd.write;
    is_rd = cmd.valid && !cmd.write;
    known = cmd.code == CMD_DELAY || cmd.code == CMD_RISE ||
            cmd.code == CMD_TMO;
    wr_c = lin_units(cmd.wdata,
                     cmd.code == CMD_RISE ? BASE_QTR : BASE_HALF);
    if (cmd.code == CMD_DELAY) begin
      wr_ok = lin_ok(wr_c, DELAY_MAX_HALF);
    end else if (cmd.code == CMD_RISE) begin
      wr_ok = lin_ok(wr_c, RISE_MAX_QTR);
    end else begin
      // Timeout word only changes by restore
      wr_ok = 1'b0;
    end
  end

  // Restore once after reset release, then on request
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      restore_pend_reg <= 1'b1;
    end else begin
      restore_pend_reg <= 1'b0;
    end
  end
  assign do_restore = restore_pend_reg || nvm_restore;

  // Timing word storage; restore beats a same-cycle write
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      delay_reg <= {DELAY_EXP_RST, MAN_RST};
      rise_reg <= {RISE_EXP_RST, MAN_RST};
      tmo_reg <= {TMO_EXP_RST, MAN_RST};
    end else if (do_restore) begin
      delay_reg <= {DELAY_EXP_RST, 1'b0, nvd_h};
      rise_reg <= {RISE_EXP_RST, nvm.rise_word[MAN_MSB:0]};
      tmo_reg <= {TMO_EXP_RST, nvm.tmo_word[MAN_MSB:0]};
    end else if (is_wr && wr_ok) begin
      if (cmd.code == CMD_DELAY) begin
        delay_reg <= cmd.wdata;
      end else begin
        rise_reg <= cmd.wdata;
      end
    end
  end

  // Read data and invalid-data notice, one cycle after the command
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.rd_valid <= is_rd && known;
      rsp_reg.invalid <= is_wr && known && !wr_ok;
      if (cmd.code == CMD_DELAY) begin
        rsp_reg.rd_data <= delay_reg;
      end else if (cmd.code == CMD_RISE) begin
        rsp_reg.rd_data <= rise_reg;
      end else if (cmd.code == CMD_TMO) begin
        rsp_reg.rd_data <= tmo_reg;
      end else begin
        rsp_reg.rd_data <= '0;
      end
    end
  end
  assign rsp = rsp_reg;

  // Phase completion terms
  always_comb begin
    init_done = init_reg == INIT_LAST;
    delay_done = init_done && phase_reg >= delay_q;
    ramp_done = tick && (phase_reg + 10'h1) >= rise_q;
    // Zero limit never arms the comparison
    tmo_hit = tmo_arm_reg && tmo_q != 10'h0 && tick &&
              (tmo_cnt_reg + 10'h1) == tmo_q &&
              !vout_at_85pct;
  end

  // Sequencer next state; losing the start condition wins
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (start_cond) state_next = ST_DELAY;
      ST_DELAY: begin
        if (!start_cond) state_next = ST_IDLE;
        else if (delay_done) state_next = ST_RAMP;
      end
      ST_RAMP: begin
        if (!start_cond) state_next = ST_IDLE;
        else if (tmo_hit && tmax_resp != RESP_IGNORE)
          state_next = ST_FAULT;
        else if (ramp_done) state_next = ST_REG;
      end
      ST_REG: begin
        if (!start_cond) state_next = ST_IDLE;
        else if (tmo_hit && tmax_resp != RESP_IGNORE)
          state_next = ST_FAULT;
      end
      ST_FAULT: begin
        // Latched off until the start condition goes away
        if (!start_cond) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign restart = state_next != state_reg;
  assign div_start = state_reg == ST_IDLE && state_next == ST_DELAY;

  sst_tick #(.CYC(QTR_CYC)) u_tick (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .restart(restart),
    .tick(tick)
  );

  // Step per tick is target over ramp ticks, so the ramp
  // length does not depend on the target voltage
  sst_div u_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(div_start),
    .dividend(vout_target),
    .divisor(rise_q[6:0]),
    .quotient(step),
    .busy()
  );

  // Phase tick counter, cleared on every state change
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= '0;
    end else if (restart) begin
      phase_reg <= '0;
    end else if (tick && (state_reg == ST_DELAY ||
                          state_reg == ST_RAMP)) begin
      phase_reg <= phase_reg + 10'h1;
    end
  end

  // Initialisation window runs alongside the delay
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_reg <= '0;
    end else if (restart) begin
      init_reg <= '0;
    end else if (state_reg == ST_DELAY && !init_done) begin
      init_reg <= init_reg + 12'h1;
    end
  end

  // Reference ramp; floored step leaves the last jump to
  // the end, which is where slopes can coincide
  assign dac_sum = {1'b0, dac_reg} + {1'b0, step};
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dac_reg <= '0;
    end else if (state_reg == ST_RAMP) begin
      if (ramp_done) begin
        dac_reg <= vout_target;
      end else if (tick) begin
        dac_reg <= dac_sum > {1'b0, vout_target} ?
                   vout_target : dac_sum[15:0];
      end
    end else if (state_reg == ST_REG) begin
      dac_reg <= vout_target;
    end else begin
      dac_reg <= '0;
    end
  end

  // Timeout watch from the end of the delay
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmo_arm_reg <= 1'b0;
      tmo_cnt_reg <= '0;
    end else if (state_reg == ST_DELAY && state_next == ST_RAMP) begin
      tmo_arm_reg <= 1'b1;
      tmo_cnt_reg <= '0;
    end else if (state_next == ST_IDLE || state_next == ST_FAULT ||
                 vout_at_85pct || tmo_hit) begin
      tmo_arm_reg <= 1'b0;
    end else if (tick && tmo_arm_reg) begin
      tmo_cnt_reg <= tmo_cnt_reg + 10'h1;
    end
  end

  // One-cycle timeout fault report
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= tmo_hit;
    end
  end

  assign dac_ref = dac_reg;
  assign ton_max_fault = fault_reg;
  assign power_enable = state_reg == ST_RAMP || state_reg == ST_REG;
  // Undervoltage watch only once the ramp is over
  assign uv_fault_enable = state_reg == ST_REG;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence dly_exit;
    state_reg == ST_DELAY ##1 state_reg == ST_RAMP;
  endsequence
  sequence ramp_exit;
    state_reg == ST_RAMP ##1 state_reg == ST_REG;
  endsequence

  delay_hold_a: assert property (
    state_reg == ST_DELAY |-> !power_enable && dac_ref == 16'h0)
    else $error("output moved during turn-on delay");
  min_delay_a: assert property (
    dly_exit |-> $past(init_reg) == INIT_LAST)
    else $error("ramp began before init window");
  rd_back_a: assert property (
    is_rd && cmd.code == CMD_DELAY |=>
      rsp.rd_valid && rsp.rd_data == $past(delay_reg))
    else $error("delay word read back wrong");
  bad_write_a: assert property (
    is_wr && cmd.code == CMD_DELAY && !wr_ok && !do_restore |=>
      rsp.invalid && $stable(delay_reg))
    else $error("invalid delay write accepted");
  tmo_write_a: assert property (
    is_wr && cmd.code == CMD_TMO && !do_restore |=>
      rsp.invalid && $stable(tmo_reg))
    else $error("timeout write not flagged");
  ramp_min_a: assert property (
    ramp_exit |-> $past(phase_reg) >= 10'h1)
    else $error("ramp shorter than two ticks");
  uv_enable_a: assert property (
    ramp_exit |-> uv_fault_enable && dac_ref == $past(vout_target))
    else $error("ramp end without uv enable");
  tmo_off_a: assert property (
    tmo_q == 10'h0 |=> !ton_max_fault)
    else $error("timeout fault with zero limit");
  fault_resp_a: assert property (
    ton_max_fault && $past(tmax_resp != RESP_IGNORE) &&
      $past(start_cond) |-> state_reg == ST_FAULT && !power_enable)
    else $error("timeout fault response not taken");
endmodule
`default_nettype wire

// ### sst_tick.sv
// Quarter-millisecond tick generator for the start-up timers
`timescale 1ns/1ps
`default_nettype none
module sst_tick import sst_pkg::*; #(
  parameter int unsigned CYC = 6250
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic restart,
  output logic tick
);
  // Last count of one tick period
  localparam logic [15:0] LAST = 16'(CYC - 1);
  logic [15:0] cnt_reg;

  // Prescaler, realigned on every phase change
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (restart || cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 16'h1;
    end
  end

  // Registered one-cycle tick
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick <= 1'b0;
    end else begin
      tick <= !restart && cnt_reg == LAST;
    end
  end
endmodule
`default_nettype wire
